// File: pmt_alu.sv
// pmt_alu.sv: 8-bit arithmetic and logic unit with status flag results
// assumes the caller gates flag_we and routes y to its destination
`timescale 1ns/1ns
`include "pmt_defs.svh"
module pmt_alu
  import pmt_pkg::*;
(
  input  wire pmt_alu_fn_t fn,
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire logic        c_in,
  input  wire logic        ac_in,
  output logic [7:0]       y,
  output logic [3:0]       flag_we,
  output logic [3:0]       flags
);

  logic [8:0] sum;
  logic [8:0] half;
  logic [7:0] ob;
  logic       ci;

  // nine bit adder shared by add, subtract, increment, decrement and adjust
  function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] z, input logic cy);
    return {1'b0, x} + {1'b0, z} + {8'h00, cy};
  endfunction

  // a is the accumulator, b the memory operand; subtract is a minus b, carry set means no borrow
  always_comb
  begin
    ob = b;
    ci = 1'b0;
    sum = 9'h000;
    half = 9'h000;
    y = b;
    flag_we = 4'h0;
    flags = 4'h0;
    unique case (fn)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
      begin
        ob = (fn == ALU_SUB || fn == ALU_SBC) ? ~b : b;
        ci = (fn == ALU_ADD) ? 1'b0 : ((fn == ALU_SUB) ? 1'b1 : c_in);
        sum = add9(a, ob, ci);
        half = add9({4'h0, a[3:0]}, {4'h0, ob[3:0]}, ci);
        y = sum[7:0];
        flags[`PMT_ST_C] = sum[8];
        flags[`PMT_ST_AC] = half[4];
        flags[`PMT_ST_OV] = (a[7] == ob[7]) && (sum[7] != a[7]);
        flag_we = 4'hf;
      end
      ALU_AND, ALU_OR, ALU_XOR, ALU_CPL:
      begin
        y = (fn == ALU_AND) ? (a & b) : (fn == ALU_OR) ? (a | b) : (fn == ALU_XOR) ? (a ^ b) : ~b;
        flag_we[`PMT_ST_Z] = 1'b1;
      end
      ALU_RR:
        y = {b[0], b[7:1]};
      ALU_RL:
        y = {b[6:0], b[7]};
      ALU_RRC, ALU_RLC:
      begin
        y = (fn == ALU_RRC) ? {c_in, b[7:1]} : {b[6:0], c_in};
        flags[`PMT_ST_C] = (fn == ALU_RRC) ? b[0] : b[7];
        flag_we[`PMT_ST_C] = 1'b1;
      end
      ALU_INC, ALU_DEC:
      begin
        sum = add9(b, (fn == ALU_INC) ? 8'h01 : 8'hff, 1'b0);
        y = sum[7:0];
        flag_we[`PMT_ST_Z] = 1'b1;
      end
      ALU_DECIMAL_ADJUST:
      begin
        // low digit first, then high digit; an earlier carry stays set
        sum = add9(a, (a[3:0] > 4'h9 || ac_in) ? 8'h06 : 8'h00, 1'b0);
        if (sum[7:4] > 4'h9 || c_in || sum[8])
          sum = add9(sum[7:0], 8'h60, 1'b0) | 9'h100;
        y = sum[7:0];
        flags[`PMT_ST_C] = sum[8];
        flag_we[`PMT_ST_C] = 1'b1;
        flag_we[`PMT_ST_Z] = 1'b1;
      end
      ALU_PASS:
        y = b;
    endcase
    flags[`PMT_ST_Z] = (y == 8'h00);
  end

endmodule

// File: pmt_core.sv
// pmt_core.sv: program store, fetch sequencer, table reads, data space and serial programming port
// assumes one 10 MHz clock, a synchronous reset and a host on the plain register port
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "pmt_defs.svh"
// What this block does
// R1: program store of 2048 words of 15 bits, for fetch and table data
// R2: any reset loads the program counter with 000H and fetches from there
// R3: table address is high pointer joined to low pointer; any word allowed
// R4: table read puts low byte in named register, upper bits in table high
// R5: table high register is read only; writes leave it unchanged
// R6: both table reads take two instruction cycles
// R7: last page of the store starts at 0700H
// R8: alu result goes to chosen destination and status flags follow it
// R9: alu adds, subtracts, adjusts, logic, rotates, steps and skip decisions
// R10: programming moves data serially on one two-way pin with external clock
// R11: last-page read ignores the high pointer, uses base plus low pointer
module pmt_core
  import pmt_pkg::*;
#(
  parameter int ADDR_W = 11
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic              prog_mode_pin,
  input  wire logic              prog_serial_clock,
  input  wire logic              prog_serial_data_i,
  output logic                   prog_serial_data_o,
  output logic                   prog_serial_data_oe,
  output logic [ADDR_W-1:0]      pc,
  output logic [6:0]             table_high_bits,
  output logic                   core_halted
);

  // ****************************************
  // parameter check and constants
  // ****************************************
  // the jump field holds 11 address bits and the pointer needs a page above the low byte
  if (ADDR_W < 9 || ADDR_W > 11)
  begin : g_bad_addr_w
    $error("pmt_core: ADDR_W must lie between 9 and 11");
  end

  localparam int DEPTH = 1 << ADDR_W;
  localparam int HI_W = ADDR_W - 8;
  localparam logic [HI_W-1:0] LAST_PAGE_HI = '1;
  localparam logic [4:0] PS_ADDR_END = 5'(ADDR_W);
  localparam logic [4:0] PS_LAST = 5'(ADDR_W + `PMT_DATA_BITS);

  // ****************************************
  // storage and state
  // ****************************************
  logic [14:0]       prog_mem [0:DEPTH-1];
  logic [7:0]        dmem [0:127];
  pmt_state_t        state;
  logic [14:0]       instr;
  logic              instr_ok;
  logic [7:0]        acc;
  logic [3:0]        status;
  logic [7:0]        tab_lo;
  logic [HI_W-1:0]   tab_hi_ptr;
  logic [ADDR_W-1:0] tab_addr;
  logic [7:0]        tab_dst;
  logic [14:0]       tab_word;

  logic [2:0]        pin_s1;
  logic [2:0]        pin_s2;
  logic [2:0]        pin_s3;
  logic [2:0]        pin_f;
  logic [2:0]        pin_f_d;
  logic [4:0]        ps_cnt;
  logic              ps_cmd_wr;
  logic [ADDR_W-1:0] ps_addr;
  logic [14:0]       ps_shift;
  logic              ps_we;
  logic              ps_active;
  logic              ps_rise;

  pmt_op_t           op;
  logic              dest_mem;
  logic [7:0]        m;
  logic [7:0]        mem_b;
  pmt_alu_fn_t       alu_fn;
  logic [7:0]        alu_b;
  logic [7:0]        alu_y;
  logic [3:0]        alu_flag_we;
  logic [3:0]        alu_flags;
  logic              ex_res;
  logic              ex_flags;
  logic              ex_skip;
  logic              ex_table;
  logic              ex_mem_we;
  logic              ex_acc_we;
  logic              cw_en;
  logic [7:0]        cw_addr;
  logic [7:0]        cw_data;
  logic              dw_en;
  logic [7:0]        dw_addr;
  logic [7:0]        dw_data;
  logic              pcl_wr;

  // ****************************************
  // shared data space read
  // ****************************************
  // upper half is general memory; unused special addresses read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a[7])
      r = dmem[a[6:0]];
    else
    begin
      case (a)
        `PMT_ADDR_ACC:        r = acc;
        `PMT_ADDR_PCL:        r = pc[7:0];
        `PMT_ADDR_TAB_LO:     r = tab_lo;
        `PMT_ADDR_TAB_HIGH:   r = {1'b0, table_high_bits};
        `PMT_ADDR_TAB_HI_PTR: r = 8'(tab_hi_ptr);
        `PMT_ADDR_STATUS:     r = {4'h0, status};
        default:              r = 8'h00;
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // programming pin synchronisers
  // ****************************************
  // three stages; a pin level is taken only once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_f <= 3'h0;
      pin_f_d <= 3'h0;
    end
    else
    begin
      pin_s1 <= {prog_mode_pin, prog_serial_clock, prog_serial_data_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
      pin_f_d <= pin_f;
    end
  end

  assign ps_active = pin_f[`PMT_PIN_MODE];
  assign ps_rise = pin_f[`PMT_PIN_CLK] & ~pin_f_d[`PMT_PIN_CLK];

  // ****************************************
  // serial programming engine
  // ****************************************
  // frame: command bit (1 write), address msb first, then 15 data bits in or out
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ps_cnt <= 5'h00;
      ps_cmd_wr <= 1'b0;
      ps_addr <= '0;
      ps_shift <= 15'h0000;
      ps_we <= 1'b0;
      prog_serial_data_oe <= 1'b0;
    end
    else
    begin
      ps_we <= 1'b0;
      if (!ps_active)
      begin
        ps_cnt <= 5'h00;
        prog_serial_data_oe <= 1'b0;
      end
      else if (ps_rise)
      begin
        ps_cnt <= (ps_cnt == PS_LAST) ? 5'h00 : ps_cnt + 5'h01;
        if (ps_cnt == 5'h00)
          ps_cmd_wr <= pin_f[`PMT_PIN_DATA];
        else if (ps_cnt <= PS_ADDR_END)
        begin
          ps_addr <= {ps_addr[ADDR_W-2:0], pin_f[`PMT_PIN_DATA]};
          // a read loads the word at the last address bit and drives it out
          if (ps_cnt == PS_ADDR_END && !ps_cmd_wr)
          begin
            ps_shift <= prog_mem[{ps_addr[ADDR_W-2:0], pin_f[`PMT_PIN_DATA]}];
            prog_serial_data_oe <= 1'b1; // R10
          end
        end
        else
          ps_shift <= {ps_shift[13:0], pin_f[`PMT_PIN_DATA]}; // R10
        if (ps_cnt == PS_LAST)
        begin
          ps_we <= ps_cmd_wr;
          prog_serial_data_oe <= 1'b0;
        end
      end
    end
  end

  assign prog_serial_data_o = ps_shift[14];

  // program store write port, only the programming engine writes it
  always_ff @(posedge mclk)
  begin
    if (ps_we)
      prog_mem[ps_addr] <= ps_shift; // R1
  end

  // ****************************************
  // instruction decode and execute
  // ****************************************
  assign op = pmt_op_t'(instr[`PMT_OP_MSB:`PMT_OP_LSB]);
  assign dest_mem = instr[`PMT_DEST_BIT];
  assign m = instr[7:0];
  assign mem_b = rd_byte(m);
  assign tab_word = prog_mem[tab_addr];

  // binary ops take acc and [m]; unary ops work on [m] except decimal adjust, which works on acc; dest bit picks [m] or acc
  always_comb
  begin
    alu_fn = ALU_PASS;
    alu_b = mem_b;
    ex_res = 1'b0;
    ex_flags = 1'b0;
    ex_skip = 1'b0;
    ex_table = 1'b0;
    if (state == PMT_RUN && instr_ok && !instr[`PMT_JUMP_BIT])
    begin
      unique case (op)
        ADD_OP, ADC_OP, SUB_OP, SBC_OP, AND_OP, OR_OP, XOR_OP, CPL_OP,
        RR_OP, RRC_OP, RL_OP, RLC_OP, INC_OP, DEC_OP, DECIMAL_ADJUST_OP:
        begin
          unique case (op)
            ADD_OP:  alu_fn = ALU_ADD;
            ADC_OP:  alu_fn = ALU_ADC;
            SUB_OP:  alu_fn = ALU_SUB;
            SBC_OP:  alu_fn = ALU_SBC;
            AND_OP:  alu_fn = ALU_AND;
            OR_OP:   alu_fn = ALU_OR;
            XOR_OP:  alu_fn = ALU_XOR;
            CPL_OP:  alu_fn = ALU_CPL;
            RR_OP:   alu_fn = ALU_RR;
            RRC_OP:  alu_fn = ALU_RRC;
            RL_OP:   alu_fn = ALU_RL;
            RLC_OP:  alu_fn = ALU_RLC;
            INC_OP:  alu_fn = ALU_INC;
            DEC_OP:  alu_fn = ALU_DEC;
            default: alu_fn = ALU_DECIMAL_ADJUST;
          endcase
          ex_res = 1'b1; // R8
          ex_flags = 1'b1; // R8
        end
        MOV_OP:
        begin
          alu_b = dest_mem ? acc : mem_b;
          ex_res = 1'b1;
        end
        MOVI_OP:
        begin
          alu_b = m;
          ex_res = 1'b1;
        end
        SZ_OP, SNZ_OP:
          ex_skip = (mem_b == 8'h00) ^ (op == SNZ_OP); // R9
        SIZ_OP, SDZ_OP:
        begin
          alu_fn = (op == SIZ_OP) ? ALU_INC : ALU_DEC;
          ex_res = 1'b1;
          ex_skip = alu_flags[`PMT_ST_Z]; // R9
        end
        TABLE_READ_OP, TABLE_READ_LAST_PAGE_OP:
          ex_table = 1'b1;
        default:
          alu_fn = ALU_PASS;
      endcase
    end
  end

  pmt_alu u_alu (
    .fn      (alu_fn),
    .a       (acc),
    .b       (alu_b),
    .c_in    (status[`PMT_ST_C]),
    .ac_in   (status[`PMT_ST_AC]),
    .y       (alu_y),
    .flag_we (alu_flag_we),
    .flags   (alu_flags)
  );

  // immediate loads always land in acc whatever the dest bit says
  assign ex_mem_we = ex_res && dest_mem && op != MOVI_OP;
  assign ex_acc_we = ex_res && !(dest_mem && op != MOVI_OP);

  // ****************************************
  // data space write path
  // ****************************************
  // a host write takes the cycle; a core write in that same cycle is dropped
  assign cw_en = ex_mem_we || state == PMT_TABLE;
  assign cw_addr = (state == PMT_TABLE) ? tab_dst : m;
  assign cw_data = (state == PMT_TABLE) ? tab_word[7:0] : alu_y; // R4
  assign dw_en = reg_wr || cw_en;
  assign dw_addr = reg_wr ? reg_addr : cw_addr;
  assign dw_data = reg_wr ? reg_wdata : cw_data;
  assign pcl_wr = dw_en && dw_addr == `PMT_ADDR_PCL;

  // ****************************************
  // fetch sequencer
  // ****************************************
  // fetch overlaps execute; jumps, skips and pcl writes turn the next slot into a dummy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= PMT_RUN;
      pc <= `PMT_RESET_VECTOR; // R2
      instr <= 15'h0000;
      instr_ok <= 1'b0;
      tab_addr <= '0;
      tab_dst <= 8'h00;
    end
    else if (ps_active)
    begin
      state <= PMT_PROG;
      instr_ok <= 1'b0;
    end
    else
    begin
      unique case (state)
        PMT_PROG:
        begin
          // leaving programming restarts the program like a reset
          state <= PMT_RUN;
          pc <= `PMT_RESET_VECTOR; // R2
        end
        PMT_TABLE:
        begin
          // second cycle of a table read, fetch resumes here
          state <= PMT_RUN; // R6
          instr <= prog_mem[pc];
          pc <= pc + ADDR_W'(1);
          instr_ok <= 1'b1;
        end
        PMT_RUN:
        begin
          if (pcl_wr)
          begin
            pc <= {pc[ADDR_W-1:8], dw_data};
            instr_ok <= 1'b0;
          end
          else if (instr_ok && instr[`PMT_JUMP_BIT])
          begin
            pc <= instr[ADDR_W-1:0];
            instr_ok <= 1'b0;
          end
          else if (ex_table)
          begin
            // pc holds so the following word is fetched in the second cycle
            state <= PMT_TABLE; // R6
            tab_dst <= m;
            if (op == TABLE_READ_LAST_PAGE_OP)
              tab_addr <= {LAST_PAGE_HI, tab_lo}; // R7 R11
            else
              tab_addr <= {tab_hi_ptr, tab_lo}; // R3
          end
          else
          begin
            instr <= prog_mem[pc];
            pc <= pc + ADDR_W'(1);
            instr_ok <= !ex_skip;
          end
        end
      endcase
    end
  end

  assign core_halted = (state == PMT_PROG);

  // ****************************************
  // special registers and general purpose memory
  // ****************************************
  // table pointers are plain read write registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tab_lo <= `PMT_BYTE_RESET;
      tab_hi_ptr <= '0;
    end
    else if (dw_en && dw_addr == `PMT_ADDR_TAB_LO)
      tab_lo <= dw_data;
    else if (dw_en && dw_addr == `PMT_ADDR_TAB_HI_PTR)
      tab_hi_ptr <= dw_data[HI_W-1:0];
  end

  // table high has no data space writer at all, so writes to its address vanish
  always_ff @(posedge mclk)
  begin
    if (rst)
      table_high_bits <= 7'h00;
    else if (state == PMT_TABLE)
      table_high_bits <= tab_word[14:8]; // R4 R5
  end

  // accumulator: data space write first, then alu result aimed at acc
  always_ff @(posedge mclk)
  begin
    if (rst)
      acc <= `PMT_BYTE_RESET;
    else if (dw_en && dw_addr == `PMT_ADDR_ACC)
      acc <= dw_data;
    else if (ex_acc_we)
      acc <= alu_y; // R8
  end

  // status: only the flags the operation touches change
  always_ff @(posedge mclk)
  begin
    if (rst)
      status <= 4'h0;
    else if (dw_en && dw_addr == `PMT_ADDR_STATUS)
      status <= dw_data[3:0];
    else if (ex_flags)
      status <= (status & ~alu_flag_we) | (alu_flags & alu_flag_we); // R8
  end

  // general purpose memory, no reset
  always_ff @(posedge mclk)
  begin
    if (dw_en && dw_addr[7])
      dmem[dw_addr[6:0]] <= dw_data;
  end

  // ****************************************
  // register port read
  // ****************************************
  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_byte(reg_addr) : 8'h00;
  end

endmodule

// File: pmt_core_sva.sv
// pmt_core_sva.sv: port-level assertions for the program store core
// assumes it is bound onto pmt_core and sees one clock domain
`timescale 1ns/1ns
module pmt_core_sva
  import pmt_pkg::*;
#(
  parameter int ADDR_W = 11
)
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              prog_mode_pin,
  input wire logic              prog_serial_clock,
  input wire logic              prog_serial_data_i,
  input wire logic              prog_serial_data_o,
  input wire logic              prog_serial_data_oe,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic [6:0]        table_high_bits,
  input wire logic              core_halted
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ****************************************
  // fetch, table high register and read data
  // ****************************************
  // first fetch comes from the vector, the next from the word after it
  sequence seq_boot;
    pc == 0 ##1 pc == 1;
  endsequence

  a_reset_vector: assert property ($fell(rst) && !prog_mode_pin |-> seq_boot)
    else $error("fetch did not start at the reset vector");
  a_halt_hold_pc: assert property (core_halted ##1 core_halted |-> $stable(pc))
    else $error("program counter moved while halted");
  a_thigh_write: assert property (reg_wr && reg_addr == 8'h08 && core_halted |=> $stable(table_high_bits))
    else $error("host write changed the table high register");
  a_thigh_halted: assert property (core_halted ##1 core_halted |-> $stable(table_high_bits))
    else $error("table high changed with no table read");
  a_thigh_read: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == {1'b0, $past(table_high_bits)})
    else $error("table high read returned a wrong byte");
  // read data lasts one cycle only, so a stale byte cannot be mistaken for a new one
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data present without a read");

  // ****************************************
  // serial programming pin
  // ****************************************
  a_oe_edge: assert property ($changed(prog_serial_data_oe) |-> $past(prog_serial_clock, 3))
    else $error("data enable changed without a serial clock edge");
  a_oe_halted: assert property (prog_serial_data_oe |-> core_halted)
    else $error("data pin driven outside programming mode");
endmodule

bind pmt_core pmt_core_sva #(.ADDR_W(ADDR_W)) chk_u (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_mode_pin(prog_mode_pin),
  .prog_serial_clock(prog_serial_clock), .prog_serial_data_i(prog_serial_data_i),
  .prog_serial_data_o(prog_serial_data_o), .prog_serial_data_oe(prog_serial_data_oe),
  .pc(pc), .table_high_bits(table_high_bits), .core_halted(core_halted));

// File: pmt_defs.svh
// pmt_defs.svh: addresses, field positions, reset values and frame lengths of the program store block
// assumes inclusion by bare name from every file that needs them
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH

// ****************************************
// reset values
// ****************************************
`define PMT_RESET_VECTOR 11'h000
`define PMT_BYTE_RESET 8'h00

// ****************************************
// data space addresses of the special registers
// ****************************************
`define PMT_ADDR_ACC 8'h05
`define PMT_ADDR_PCL 8'h06
`define PMT_ADDR_TAB_LO 8'h07
`define PMT_ADDR_TAB_HIGH 8'h08
`define PMT_ADDR_TAB_HI_PTR 8'h09
`define PMT_ADDR_STATUS 8'h0a

// ****************************************
// status bits and instruction fields
// ****************************************
`define PMT_ST_C 0
`define PMT_ST_AC 1
`define PMT_ST_Z 2
`define PMT_ST_OV 3
`define PMT_JUMP_BIT 14
`define PMT_OP_MSB 13
`define PMT_OP_LSB 9
`define PMT_DEST_BIT 8

// ****************************************
// serial programming pins after synchronising, and data bits per frame
// ****************************************
`define PMT_PIN_DATA 0
`define PMT_PIN_CLK 1
`define PMT_PIN_MODE 2
`define PMT_DATA_BITS 15

`endif

// File: pmt_pkg.sv
// pmt_pkg.sv: operation, alu function and sequencer state types
// assumes nothing beyond a SystemVerilog compiler
package pmt_pkg;

  // ****************************************
  // types
  // ****************************************
  // instruction operation field, codes above the last are illegal and act as no operation
  typedef enum logic [4:0] {
    NOP_OP, ADD_OP, ADC_OP, SUB_OP, SBC_OP, AND_OP, OR_OP, XOR_OP,
    CPL_OP, RR_OP, RRC_OP, RL_OP, RLC_OP, INC_OP, DEC_OP, DECIMAL_ADJUST_OP,
    MOV_OP, MOVI_OP, SZ_OP, SNZ_OP, SIZ_OP, SDZ_OP, TABLE_READ_OP, TABLE_READ_LAST_PAGE_OP
  } pmt_op_t;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_DECIMAL_ADJUST
  } pmt_alu_fn_t;

  typedef enum logic [1:0] {
    PMT_RUN, PMT_TABLE, PMT_PROG
  } pmt_state_t;

endpackage

// File: pmt_prog_model.sv
// pmt_prog_model.sv: external serial programmer driving mode, clock and the shared data line
// assumes the bench resolves the data line with a pull-up when nobody drives it
`timescale 1ns/1ns
module pmt_prog_model (
  input  wire logic mclk,
  input  wire logic data_wire,
  output logic      mode,
  output logic      sclk,
  output logic      data_drv,
  output logic      data_en
);
  // idle: clock parked low between frames, line released
  initial
  begin
    mode = 1'b0;
    sclk = 1'b0;
    data_drv = 1'b0;
    data_en = 1'b0;
  end

  // mode changes get time to pass the pin filter
  task automatic set_mode(input logic m);
    mode <= m;
    repeat (10) @(posedge mclk);
  endtask

  // one frame: command bit, address msb first, then 15 data bits msb first
  task automatic frame(input logic wr, input logic [10:0] addr, input logic [14:0] wd, output logic [14:0] rd);
    logic [26:0] bits;
    bits = {wr, addr, wd};
    rd = '0;
    for (int i = 0; i < 27; i++)
    begin
      data_en <= (i < 12) || wr;
      data_drv <= bits[26-i];
      repeat (5) @(posedge mclk);
      if (i >= 12)
        rd[26-i] = data_wire;
      sclk <= 1'b1;
      repeat (5) @(posedge mclk);
      sclk <= 1'b0;
    end
    data_en <= 1'b0;
    // one idle cycle so a following frame never drives the enable twice in one step
    @(posedge mclk);
  endtask
endmodule

// File: testbench.sv
// testbench.sv: self-checking bench loading a program serially, then checking table reads
// assumes the core, its checker and the programmer model are compiled before it
`timescale 1ns/1ns
`include "pmt_defs.svh"
module testbench
  import pmt_pkg::*;
;
  typedef struct { logic [7:0] addr; logic [7:0] exp; } pmt_row_t;
  logic        mclk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        mode;
  logic        sclk;
  logic        drv;
  logic        drv_en;
  logic        data_o;
  logic        data_oe;
  logic        pin;
  logic [10:0] pc;
  logic [6:0]  table_high_bits;
  logic        core_halted;
  logic [14:0] word;
  logic [7:0]  b;
  int          num_errors;
  int          checked;
  int          run_cnt;
  // program: pointers, both table reads, add to zero, decimal adjust into 82, taken skip over a load
  logic [25:0] prog [14] = '{{11'h000, 15'h2206}, {11'h001, 15'h2107}, {11'h002, 15'h2203},
    {11'h003, 15'h2109}, {11'h004, 15'h2d80}, {11'h005, 15'h2f81}, {11'h006, 15'h22cc},
    {11'h007, 15'h0280}, {11'h008, 15'h1f82}, {11'h009, 15'h2401}, {11'h00a, 15'h22ff},
    {11'h00b, 15'h400b}, {11'h306, 15'h1234}, {11'h706, 15'h5b3c}};
  pmt_row_t rows [9] = '{'{`PMT_ADDR_ACC, 8'h00}, '{`PMT_ADDR_TAB_LO, 8'h06}, '{`PMT_ADDR_TAB_HI_PTR, 8'h03},
    '{`PMT_ADDR_TAB_HIGH, 8'h5b}, '{`PMT_ADDR_STATUS, 8'h03}, '{8'h80, 8'h34}, '{8'h81, 8'h3c}, '{8'h01, 8'h00},
    '{8'h82, 8'h66}};

  // pull-up keeps the released line high; the device wins while it drives
  assign pin = data_oe ? data_o : (drv_en ? drv : 1'b1);

  pmt_core #(.ADDR_W(11)) dut_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_mode_pin(mode), .prog_serial_clock(sclk),
    .prog_serial_data_i(pin), .prog_serial_data_o(data_o), .prog_serial_data_oe(data_oe),
    .pc(pc), .table_high_bits(table_high_bits), .core_halted(core_halted));
  pmt_prog_model prog_u (
    .mclk(mclk), .data_wire(pin), .mode(mode), .sclk(sclk), .data_drv(drv), .data_en(drv_en));

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // cycles since the core left programming, to time the table reads
  always @(posedge mclk)
    run_cnt <= core_halted ? 0 : run_cnt + 1;

  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read byte stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    prog_u.set_mode(1'b1);
    check("halted", 15'h0001, {14'h0, core_halted});
    wr(`PMT_ADDR_TAB_HIGH, 8'h7f);
    foreach (prog[i])
      prog_u.frame(1'b1, prog[i][25:15], prog[i][14:0], word);
    prog_u.frame(1'b0, 11'h706, 15'h0000, word);
    check("serial readback", 15'h5b3c, word);
    $display("test serial load done");
    prog_u.set_mode(1'b0);
    // nine fetch slots to reach word 9, plus one extra slot for each of the two table reads
    while (pc !== 11'h009)
      @(negedge mclk);
    check("cycles to pc 9", 15'h000b, 15'(run_cnt));
    repeat (80) @(posedge mclk);
    foreach (rows[i])
    begin
      rd(rows[i].addr, b);
      check("register byte", {7'h00, rows[i].exp}, {7'h00, b});
    end
    $display("test table reads done");
    wr(`PMT_ADDR_TAB_HIGH, 8'h00);
    rd(`PMT_ADDR_TAB_HIGH, b);
    check("table high after write", 15'h005b, {7'h00, b});
    $display("test read only done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("pc in reset", {4'h0, `PMT_RESET_VECTOR}, {4'h0, pc});
    check("table high in reset", 15'h0000, {8'h00, table_high_bits});
    @(posedge mclk);
    rst <= 1'b0;
    repeat (20) @(posedge mclk);
    $display("test second reset done");
    summarize();
  end

  // watchdog well beyond the roughly 0.4 ms the sequence needs
  initial
  begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule
